/* rtl/txpdo_event_trigger.sv */
// transmit object event trigger with AXI4-Lite register slave
module txpdo_event_trigger (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               srst,
  // register bus
  input  wire txev_pkg::axi_req_s axi_req,
  output txev_pkg::axi_rsp_s      axi_rsp,
  // event sources from pins and the drive core
  input  wire txev_pkg::src_s     src_in,
  // sequence flag clear pulses back to the sequence program
  output logic [1:0]              flag_clear,
  // send requests, one-cycle pulses in the cycle after the tick
  output logic [1:0]              send_req,
  // remap permission per object index (0 fixed, 1 user)
  output logic [1:0]              remap_allow,
  // interrupt
  output logic                    irq
);
  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    txev_pkg::src_s    sync1;
    txev_pkg::src_s    sync2;
    txev_pkg::src_s    prev;
    logic [15:0]       tick_cnt;
    logic [15:0]       cyc_cnt1;
    logic [15:0]       cyc_cnt2;
    logic [15:0]       mask1;
    logic [15:0]       mask2;
    logic [7:0]        ttype1;
    logic [7:0]        ttype2;
    logic [15:0]       period;
    logic [1:0]        irq_stat;
    logic [1:0]        irq_mask;
    logic              aw_got;
    logic [7:0]        aw_addr;
    logic              w_got;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    txev_pkg::axi_rsp_s rsp;
    logic [1:0]        flag_clr;
    logic [1:0]        send;
    logic              irq;
    logic [1:0]        remap;
  } state_s;

  state_s st_ff;
  state_s nxt_st;

  logic              tick;
  logic [15:0]       ev_vec;
  logic [15:0]       hit1;
  logic [15:0]       hit2;
  logic              cyc1_due;
  logic              cyc2_due;
  logic              fire1;
  logic              fire2;
  logic              wr_do;
  logic [31:0]       wmask;
  logic [31:0]       rd_val;
  logic              rd_ok;
  logic              wr_ok;

  ////////////////////////////////////////////////////////////////////////
  // event vector from sampled sources versus previous tick
  always_comb begin
    tick = (st_ff.tick_cnt ==
            16'(txev_pkg::TICK_CYCLES - 1));
    ev_vec = 16'h0000;
    ev_vec[txev_pkg::BIT_DIN_LO +: txev_pkg::NUM_DIN] =
      st_ff.sync2.din ^ st_ff.prev.din;
    ev_vec[txev_pkg::BIT_VOUT_LO +: 2] =
      st_ff.sync2.vout ^ st_ff.prev.vout;
    ev_vec[txev_pkg::BIT_FLAG_A] = st_ff.sync2.flag_a;
    ev_vec[txev_pkg::BIT_FLAG_B] = st_ff.sync2.flag_b;
    ev_vec[txev_pkg::BIT_CANSTAT] =
      (st_ff.sync2.can_word != st_ff.prev.can_word);
    ev_vec[txev_pkg::BIT_SYSSTAT] =
      (st_ff.sync2.sys_word != st_ff.prev.sys_word);
    // cyclic timers count control ticks
    cyc1_due = (st_ff.cyc_cnt1 + 16'h0001 >= st_ff.period);
    cyc2_due = (st_ff.cyc_cnt2 + 16'h0001 >= st_ff.period);
    hit1 = ev_vec;
    hit2 = ev_vec;
    hit1[txev_pkg::BIT_CYCLIC] = cyc1_due;
    hit2[txev_pkg::BIT_CYCLIC] = cyc2_due;
    // separate masks, any enabled source fires, async type only
    fire1 = tick && (st_ff.ttype1 == txev_pkg::TTYPE_ASYNC) &&
            |(hit1 & st_ff.mask1);
    fire2 = tick && (st_ff.ttype2 == txev_pkg::TTYPE_ASYNC) &&
            |(hit2 & st_ff.mask2);
  end

  ////////////////////////////////////////////////////////////////////////
  // register read mux; unmapped addresses answer slverr
  always_comb begin
    rd_val = 32'h00000000;
    rd_ok  = 1'b1;
    case (axi_req.araddr)
      txev_pkg::ADDR_MASK1:    rd_val[15:0] = st_ff.mask1;
      txev_pkg::ADDR_MASK2:    rd_val[15:0] = st_ff.mask2;
      txev_pkg::ADDR_TTYPE:    rd_val[15:0] = {st_ff.ttype2, st_ff.ttype1};
      txev_pkg::ADDR_PERIOD:   rd_val[15:0] = st_ff.period;
      txev_pkg::ADDR_IRQ_STAT: rd_val[1:0]  = st_ff.irq_stat;
      txev_pkg::ADDR_IRQ_MASK: rd_val[1:0]  = st_ff.irq_mask;
      txev_pkg::ADDR_MAPCTL:   rd_val[1:0]  = st_ff.remap;
      default:                 rd_ok        = 1'b0;
    endcase
    wmask = {{8{st_ff.w_strb[3]}}, {8{st_ff.w_strb[2]}},
             {8{st_ff.w_strb[1]}}, {8{st_ff.w_strb[0]}}};
    wr_do = st_ff.aw_got && st_ff.w_got && !st_ff.rsp.bvalid;
    case (st_ff.aw_addr)
      txev_pkg::ADDR_MASK1, txev_pkg::ADDR_MASK2, txev_pkg::ADDR_TTYPE,
      txev_pkg::ADDR_PERIOD, txev_pkg::ADDR_IRQ_STAT,
      txev_pkg::ADDR_IRQ_MASK, txev_pkg::ADDR_MAPCTL: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_st = st_ff;
    // two-flop synchroniser on every source
    nxt_st.sync1 = src_in;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.flag_clr = 2'b00;
    nxt_st.send = 2'b00;
    nxt_st.tick_cnt = tick ? 16'h0000 : st_ff.tick_cnt + 16'h0001;
    if (tick) begin
      nxt_st.prev = st_ff.sync2;
      nxt_st.cyc_cnt1 = cyc1_due ? 16'h0000 : st_ff.cyc_cnt1 + 16'h0001;
      nxt_st.cyc_cnt2 = cyc2_due ? 16'h0000 : st_ff.cyc_cnt2 + 16'h0001;
      // one send per object per tick, no request needed
      nxt_st.send = {fire2, fire1};
      // flags are consumed once evaluated
      nxt_st.flag_clr = {st_ff.sync2.flag_b, st_ff.sync2.flag_a};
    end
    // write address and data channels, either order
    if (axi_req.awvalid && st_ff.rsp.awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st_ff.rsp.wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.w_data = axi_req.wdata;
      nxt_st.w_strb = axi_req.wstrb;
    end
    nxt_st.rsp.awready = !nxt_st.aw_got;
    nxt_st.rsp.wready  = !nxt_st.w_got;
    // interrupt status: send pulses set, write-one clears, set wins
    nxt_st.irq_stat = st_ff.irq_stat;
    if (wr_do) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.rsp.awready = 1'b1;
      nxt_st.rsp.wready  = 1'b1;
      nxt_st.rsp.bvalid = 1'b1;
      nxt_st.rsp.bresp = wr_ok ? txev_pkg::RESP_OKAY
                               : txev_pkg::RESP_SLVERR;
      case (st_ff.aw_addr)
        txev_pkg::ADDR_MASK1: nxt_st.mask1 =
          (st_ff.mask1 & ~wmask[15:0]) | (st_ff.w_data[15:0] & wmask[15:0]);
        txev_pkg::ADDR_MASK2: nxt_st.mask2 =
          (st_ff.mask2 & ~wmask[15:0]) | (st_ff.w_data[15:0] & wmask[15:0]);
        txev_pkg::ADDR_TTYPE: begin
          if (st_ff.w_strb[0]) nxt_st.ttype1 = st_ff.w_data[7:0];
          if (st_ff.w_strb[1]) nxt_st.ttype2 = st_ff.w_data[15:8];
        end
        txev_pkg::ADDR_PERIOD: nxt_st.period =
          (st_ff.period & ~wmask[15:0]) | (st_ff.w_data[15:0] & wmask[15:0]);
        txev_pkg::ADDR_IRQ_STAT: if (st_ff.w_strb[0])
          nxt_st.irq_stat = st_ff.irq_stat & ~st_ff.w_data[1:0];
        txev_pkg::ADDR_IRQ_MASK: if (st_ff.w_strb[0])
          nxt_st.irq_mask = st_ff.w_data[1:0];
        default: ;  // map control is read-only: object 1 stays fixed
      endcase
    end
    nxt_st.irq_stat = nxt_st.irq_stat | nxt_st.send;
    if (st_ff.rsp.bvalid && axi_req.bready) nxt_st.rsp.bvalid = 1'b0;
    // read channel, single outstanding
    if (st_ff.rsp.rvalid) begin
      if (axi_req.rready) nxt_st.rsp.rvalid = 1'b0;
      nxt_st.rsp.arready = 1'b0;
    end
    if (axi_req.arvalid && st_ff.rsp.arready) begin
      nxt_st.rsp.arready = 1'b0;
      nxt_st.rsp.rvalid = 1'b1;
      nxt_st.rsp.rdata = rd_val;
      nxt_st.rsp.rresp = rd_ok ? txev_pkg::RESP_OKAY
                               : txev_pkg::RESP_SLVERR;
    end else if (!st_ff.rsp.rvalid || axi_req.rready) begin
      nxt_st.rsp.arready = !(st_ff.rsp.rvalid && !axi_req.rready);
    end
    nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_ff <= '0;
      st_ff.mask1  <= txev_pkg::MASK_RESET;
      st_ff.mask2  <= txev_pkg::MASK_RESET;
      st_ff.ttype1 <= txev_pkg::TTYPE_RESET;
      st_ff.ttype2 <= txev_pkg::TTYPE_RESET;
      st_ff.period <= txev_pkg::PERIOD_RESET;
      st_ff.remap  <= txev_pkg::REMAP_ALLOW;
      st_ff.rsp.awready <= 1'b1;
      st_ff.rsp.wready  <= 1'b1;
      st_ff.rsp.arready <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flops
  assign axi_rsp     = st_ff.rsp;
  assign flag_clear  = st_ff.flag_clr;
  assign send_req    = st_ff.send;
  assign remap_allow = st_ff.remap;
  assign irq         = st_ff.irq;

  ////////////////////////////////////////////////////////////////////////
  // checks
  // sends leave only on the cycle after a control tick
  chk_send_on_tick: assert property (
    @(posedge core_clk) disable iff (srst)
    |send_req |-> $past(tick))
    else $error("send off tick");
  // object 1 may only send while its type is the asynchronous code
  chk_async_only: assert property (
    @(posedge core_clk) disable iff (srst)
    send_req[0] |-> $past(st_ff.ttype1) == txev_pkg::TTYPE_ASYNC)
    else $error("send in non-async mode");
  // same gate for object 2, checked on its own type field
  chk_obj2_async: assert property (
    @(posedge core_clk) disable iff (srst)
    send_req[1] |-> $past(st_ff.ttype2) == txev_pkg::TTYPE_ASYNC)
    else $error("object 2 send in non-async mode");
  // synchronous type: pending events are dropped, not queued
  chk_sync_quiet: assert property (
    @(posedge core_clk) disable iff (srst)
    (tick && st_ff.ttype1 != txev_pkg::TTYPE_ASYNC) |=> !send_req[0])
    else $error("mask event sent in sync mode");
  // an empty mask never sends, whatever the sources do
  chk_mask_gate: assert property (
    @(posedge core_clk) disable iff (srst)
    (tick && st_ff.mask1 == 16'h0000) |=> !send_req[0])
    else $error("send with empty mask");
  // object 2 follows only its own mask, not that of object 1
  chk_mask2_gate: assert property (
    @(posedge core_clk) disable iff (srst)
    (tick && st_ff.mask2 == 16'h0000) |=> !send_req[1])
    else $error("object 2 send with empty mask");
  // cyclic bit: the period counter running out is a send on its own
  chk_cyclic_send: assert property (
    @(posedge core_clk) disable iff (srst)
    (tick && st_ff.ttype1 == txev_pkg::TTYPE_ASYNC &&
     st_ff.mask1[txev_pkg::BIT_CYCLIC] &&
     st_ff.cyc_cnt1 + 16'h0001 >= st_ff.period) |=> send_req[0])
    else $error("cyclic send missed");
  // an input edge in either direction on an enabled bit sends
  chk_din_edge: assert property (
    @(posedge core_clk) disable iff (srst)
    (tick && st_ff.ttype1 == txev_pkg::TTYPE_ASYNC && st_ff.mask1[1] &&
     st_ff.sync2.din[0] != st_ff.prev.din[0]) |=> send_req[0])
    else $error("input edge missed");
  // virtual outputs have no pin but are edge-checked the same way
  chk_vout_edge: assert property (
    @(posedge core_clk) disable iff (srst)
    (tick && st_ff.ttype2 == txev_pkg::TTYPE_ASYNC && st_ff.mask2[10] &&
     st_ff.sync2.vout[0] != st_ff.prev.vout[0]) |=> send_req[1])
    else $error("virtual output edge missed");
  // sequence flags send on the tick at which they are seen set
  chk_flag_a_event: assert property (
    @(posedge core_clk) disable iff (srst)
    (tick && st_ff.ttype1 == txev_pkg::TTYPE_ASYNC &&
     st_ff.mask1[txev_pkg::BIT_FLAG_A] && st_ff.sync2.flag_a)
    |=> send_req[0])
    else $error("flag a event missed");
  chk_flag_b_event: assert property (
    @(posedge core_clk) disable iff (srst)
    (tick && st_ff.ttype2 == txev_pkg::TTYPE_ASYNC &&
     st_ff.mask2[txev_pkg::BIT_FLAG_B] && st_ff.sync2.flag_b)
    |=> send_req[1])
    else $error("flag b event missed");
  // every flag seen at a tick is handed back for clearing
  chk_flag_clear: assert property (
    @(posedge core_clk) disable iff (srst)
    (tick && st_ff.sync2.flag_a) |=> flag_clear[0])
    else $error("flag not cleared");
  chk_flag_b_clear: assert property (
    @(posedge core_clk) disable iff (srst)
    (tick && st_ff.sync2.flag_b) |=> flag_clear[1])
    else $error("flag b not cleared");
  // status words are compared whole against the last tick sample
  chk_can_change: assert property (
    @(posedge core_clk) disable iff (srst)
    (tick && st_ff.ttype1 == txev_pkg::TTYPE_ASYNC && st_ff.mask1[14] &&
     st_ff.sync2.can_word != st_ff.prev.can_word) |=> send_req[0])
    else $error("can word change missed");
  chk_sys_change: assert property (
    @(posedge core_clk) disable iff (srst)
    (tick && st_ff.ttype2 == txev_pkg::TTYPE_ASYNC && st_ff.mask2[15] &&
     st_ff.sync2.sys_word != st_ff.prev.sys_word) |=> send_req[1])
    else $error("status change missed");
  // one pulse per tick even when several sources fire together
  chk_single_send: assert property (
    @(posedge core_clk) disable iff (srst)
    send_req[0] |=> !send_req[0])
    else $error("double send");
  // interrupt rises with the status bit when that bit is unmasked
  chk_irq_level: assert property (
    @(posedge core_clk) disable iff (srst)
    $rose(st_ff.irq_stat[0]) && st_ff.irq_mask[0] |-> irq)
    else $error("irq missing");
  // register bus: read data one cycle after the address is taken
  chk_rd_answer: assert property (
    @(posedge core_clk) disable iff (srst)
    (axi_req.arvalid && axi_rsp.arready) |=> axi_rsp.rvalid)
    else $error("read answer missing");
  // write response one cycle after both halves are held
  chk_wr_answer: assert property (
    @(posedge core_clk) disable iff (srst)
    (st_ff.aw_got && st_ff.w_got && !axi_rsp.bvalid) |=> axi_rsp.bvalid)
    else $error("write response missing");
  // main scenarios: each object sending, both at once, interrupt
  cov_send1: cover property (@(posedge core_clk) send_req[0]);
  cov_send2: cover property (@(posedge core_clk) send_req[1]);
  cov_both: cover property (@(posedge core_clk) &send_req);
  cov_irq: cover property (@(posedge core_clk) $rose(irq));
endmodule

/* rtl/txev_pkg.sv */
// package: register map, field positions and timing for the transmit trigger
package txev_pkg;
  // register byte addresses (one aligned word each)
  localparam logic [7:0] ADDR_MASK1    = 8'h00;
  localparam logic [7:0] ADDR_MASK2    = 8'h04;
  localparam logic [7:0] ADDR_TTYPE    = 8'h08;
  localparam logic [7:0] ADDR_PERIOD   = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  localparam logic [7:0] ADDR_MAPCTL   = 8'h18;
  // mask bit positions
  localparam int BIT_CYCLIC  = 0;
  localparam int BIT_DIN_LO  = 1;
  localparam int BIT_VOUT_LO = 10;
  localparam int BIT_FLAG_A  = 12;
  localparam int BIT_FLAG_B  = 13;
  localparam int BIT_CANSTAT = 14;
  localparam int BIT_SYSSTAT = 15;
  localparam int NUM_DIN     = 9;
  // transmission type codes
  localparam logic [7:0] TTYPE_ASYNC = 8'hFE;
  localparam logic [7:0] TTYPE_RESET = 8'hFE;
  localparam logic [15:0] MASK_RESET   = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'h000A;
  localparam logic [1:0]  REMAP_ALLOW  = 2'b10;  // object 2 only remappable
  // control tick: 1 ms at 20 MHz
  localparam int TICK_NS     = 1000000;
  localparam int CLK_NS      = 50;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // event sources sampled on the control tick
  typedef struct packed {
    logic [8:0]  din;
    logic [1:0]  vout;
    logic        flag_a;
    logic        flag_b;
    logic [15:0] can_word;
    logic [15:0] sys_word;
  } src_s;

  // AXI4-Lite requests from master
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_s;
endpackage

/* sim/seq_flag_model.sv */
// partner: sequence program flags and receiver of transmit requests
module seq_flag_model (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       srst,
  // bench side
  input  wire logic [1:0] set_flag,
  output logic [1:0]      flags,
  output logic [7:0]      cnt1,
  output logic [7:0]      cnt2,
  output logic [7:0]      clr_cnt,
  // trigger block side
  input  wire logic [1:0] flag_clear,
  input  wire logic [1:0] send_req
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] flags_ff;
  logic [7:0] cnt1_ff;
  logic [7:0] cnt2_ff;
  logic [7:0] clr_ff;
  //////////////////////////////////////////////////////////////////////////
  // flags set by the program, dropped only when the block asks
  // no control objects are sent here, so 1 ms spacing holds
  always_ff @(posedge core_clk) begin
    if (srst) begin
      flags_ff <= 2'h0;
      cnt1_ff  <= 8'h00;
      cnt2_ff  <= 8'h00;
      clr_ff   <= 8'h00;
    end else begin
      flags_ff <= (flags_ff | set_flag) & ~flag_clear;
      cnt1_ff  <= cnt1_ff + {7'h00, send_req[0]};
      cnt2_ff  <= cnt2_ff + {7'h00, send_req[1]};
      clr_ff   <= clr_ff + {7'h00, flag_clear[0]} + {7'h00, flag_clear[1]};
    end
  end
  // counts are cumulative so the bench never has to clear them
  assign flags   = flags_ff;
  assign cnt1    = cnt1_ff;
  assign cnt2    = cnt2_ff;
  assign clr_cnt = clr_ff;
endmodule

/* sim/tb_top.sv */
// testbench: register access and per-tick trigger sequences
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic               core_clk;
  logic               srst;
  txev_pkg::axi_req_s req;
  txev_pkg::axi_rsp_s rsp;
  txev_pkg::src_s     src;
  logic [8:0]         din;
  logic [1:0]         vout;
  logic [15:0]        can_word;
  logic [15:0]        sys_word;
  logic [1:0]         set_flag;
  logic [1:0]         flags;
  logic [1:0]         flag_clear;
  logic [1:0]         send_req;
  logic [1:0]         remap_allow;
  logic               irq;
  logic [7:0]         cnt1;
  logic [7:0]         cnt2;
  logic [7:0]         clr_cnt;
  logic [31:0]        rd;
  logic [1:0]         rr;
  int                 cyc;
  int                 failures;
  int                 total_checks;
  //////////////////////////////////////////////////////////////////////////
  assign src = {din, vout, flags[0], flags[1], can_word, sys_word};
  txpdo_event_trigger uut (.core_clk(core_clk), .srst(srst),
    .axi_req(req), .axi_rsp(rsp), .src_in(src), .flag_clear(flag_clear),
    .send_req(send_req), .remap_allow(remap_allow), .irq(irq));
  seq_flag_model partner (.core_clk(core_clk), .srst(srst),
    .set_flag(set_flag), .flags(flags), .cnt1(cnt1), .cnt2(cnt2),
    .clr_cnt(clr_cnt), .flag_clear(flag_clear), .send_req(send_req));
  //////////////////////////////////////////////////////////////////////////
  // clock and a cycle count since reset release
  initial begin
    core_clk = 1'h0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc <= srst ? 0 : cyc + 1;
  task automatic end_sim();
    $display("failures=%0d total_checks=%0d", failures, total_checks);
    if (failures == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one write; valid lines drop on the edge that takes them
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    req.awaddr <= a;
    req.awvalid <= 1'h1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.wvalid <= 1'h1;
    req.bready <= 1'h1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge core_clk);
      if (rsp.awready) req.awvalid <= 1'h0;
      if (rsp.wready) req.wvalid <= 1'h0;
    end while (rsp.bvalid !== 1'h1);
    req.bready <= 1'h0;
    check({30'h0, rsp.bresp}, {30'h0, txev_pkg::RESP_OKAY});
  endtask
  // one read, then data and response compared
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
    @(posedge core_clk);
    req.araddr <= a;
    req.arvalid <= 1'h1;
    req.rready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (rsp.arready) req.arvalid <= 1'h0;
    end while (rsp.rvalid !== 1'h1);
    rd = rsp.rdata;
    rr = rsp.rresp;
    req.rready <= 1'h0;
    check(rd, e);
    check({30'h0, rr}, {30'h0, er});
  endtask
  // tick timing is fixed by the block, so waits are counted cycles
  task automatic wait_to(input int n);
    while (cyc < n) @(posedge core_clk);
  endtask
  // four ticks plus setup take about 80k cycles; stop short of 100k
  initial begin
    #4500000;
    failures++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_sim();
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    req = '0;
    srst = 1'h1;
    din = 9'h000;
    vout = 2'h0;
    can_word = 16'h0000;
    sys_word = 16'h0000;
    set_flag = 2'h0;
    failures = 0;
    total_checks = 0;
    repeat (20) @(posedge core_clk);
    srst <= 1'h0;
    rchk(txev_pkg::ADDR_MASK1, 32'h0, txev_pkg::RESP_OKAY);
    rchk(txev_pkg::ADDR_TTYPE, 32'hFEFE, txev_pkg::RESP_OKAY);
    rchk(txev_pkg::ADDR_PERIOD, 32'hA, txev_pkg::RESP_OKAY);
    rchk(txev_pkg::ADDR_MAPCTL, 32'h2, txev_pkg::RESP_OKAY);
    rchk(8'h1C, 32'h0, txev_pkg::RESP_SLVERR);
    check({30'h0, remap_allow}, 32'h2);
    // tick 1: input rising edge on object 1 only
    axw(txev_pkg::ADDR_MASK1, 32'h0002);
    axw(txev_pkg::ADDR_MASK2, 32'h8000);
    rchk(txev_pkg::ADDR_MASK2, 32'h8000, txev_pkg::RESP_OKAY);
    din[0] <= 1'h1;
    wait_to(19980);
    check({24'h0, cnt1}, 32'h0);
    wait_to(20010);
    check({24'h0, cnt1}, 32'h1);
    check({24'h0, cnt2}, 32'h0);
    // interrupt raised while masked, then unmasked, then cleared
    rchk(txev_pkg::ADDR_IRQ_STAT, 32'h1, txev_pkg::RESP_OKAY);
    check({31'h0, irq}, 32'h0);
    axw(txev_pkg::ADDR_IRQ_MASK, 32'h3);
    repeat (2) @(posedge core_clk);
    check({31'h0, irq}, 32'h1);
    axw(txev_pkg::ADDR_IRQ_STAT, 32'h1);
    repeat (2) @(posedge core_clk);
    check({31'h0, irq}, 32'h0);
    // tick 2: falling edge ignored in sync mode, status change sends
    axw(txev_pkg::ADDR_TTYPE, 32'hFE01);
    din[0] <= 1'h0;
    sys_word <= 16'h0001;
    wait_to(40010);
    check({24'h0, cnt1}, 32'h1);
    check({24'h0, cnt2}, 32'h1);
    // tick 3: flags and several sources at once
    axw(txev_pkg::ADDR_TTYPE, 32'hFEFE);
    axw(txev_pkg::ADDR_MASK1, 32'h5000);
    axw(txev_pkg::ADDR_MASK2, 32'h6400);
    set_flag <= 2'h3;
    vout <= 2'h1;
    can_word <= 16'h0003;
    @(posedge core_clk);
    set_flag <= 2'h0;
    wait_to(60010);
    check({24'h0, cnt1}, 32'h2);
    check({24'h0, cnt2}, 32'h2);
    check({24'h0, clr_cnt}, 32'h2);
    check({30'h0, flags}, 32'h0);
    // tick 4: cyclic send, disabled source ignored
    axw(txev_pkg::ADDR_PERIOD, 32'h1);
    axw(txev_pkg::ADDR_MASK1, 32'h1);
    axw(txev_pkg::ADDR_MASK2, 32'h0);
    din[2] <= 1'h1;
    wait_to(80010);
    check({24'h0, cnt1}, 32'h3);
    check({24'h0, cnt2}, 32'h2);
    end_sim();
  end
endmodule
